// ==== src/fps_perchan_sync_status.v ====
`timescale 1ns/1ps
`include "fps_regs.vh"
module fps_perchan_sync_status
#(
   parameter SEARCH_CYC = `FPS_SEARCH_CYC,
   parameter NCHAN      = 32
)
(
   // Clock and reset
   input  wire             CLK_SYS,
   input  wire             RST_N,
   input  wire             CE,
   // Register port
   input  wire [7:0]       ADDR,
   input  wire [7:0]       WDATA,
   input  wire             WR,
   input  wire             RD,
   output reg  [7:0]       RDATA,
   // Synchronizer and BERT status from the framer
   input  wire             FRAME_SEARCH,
   input  wire             CAS_SEARCH,
   input  wire             CRC_SEARCH,
   input  wire             BERT_MATCH_BIT,
   input  wire             BERT_BIT_VALID,
   // Per-channel enables, one per timeslot
   output reg  [NCHAN-1:0] RX_SIG_ONES_INSERT_EN,
   output reg  [NCHAN-1:0] RX_SIG_REINSERT_EN,
   output reg  [NCHAN-1:0] RX_FRACTIONAL_EN,
   output reg  [NCHAN-1:0] BERT_RX_CHANNEL_EN,
   output reg  [NCHAN-1:0] TX_HW_SIGNALING_EN,
   output reg  [NCHAN-1:0] PAYLOAD_ERROR_INSERT_EN,
   output reg  [NCHAN-1:0] TX_FRACTIONAL_EN,
   output reg  [NCHAN-1:0] BERT_TX_CHANNEL_EN,
   // Receive HDLC controls
   output reg  [1:0]       RX_HDLC_RESET,
   output reg  [1:0]       RX_HDLC_MAP_SELECT,
   output reg  [1:0]       RX_FILL_UNIT_DELETE,
   // Status and interrupt
   output reg              BERT_IN_SYNC,
   output reg              IRQ
);

   reg  [7:0]  pcptr_q;
   reg  [31:0] pcdata_q;
   reg  [7:0]  hrx1_q;
   reg  [7:0]  hrx2_q;
   reg         crc_en_q;
   reg  [5:0]  cnt_q;
   reg  [22:0] tmr_q;
   reg  [5:0]  run_q;
   reg         sync_q;
   reg  [1:0]  ist_q;
   reg  [1:0]  imask_q;
   reg         rst1_q;
   reg         rst2_q;
   reg         crc_srch_q;

   wire        wr_en = CE & WR;
   wire        rd_en = CE & RD;
   wire [7:0]  stat_live;
   wire        tmr_done;
   wire        bert_in_sync_edge;
   wire        srch_tick;
   wire        sync_d;

   function [7:0] sel_byte;
      input [7:0]  a;
      input [31:0] d;
      begin
         case (a)
            `FPS_ADDR_PCDATA1: sel_byte = d[7:0];
            `FPS_ADDR_PCDATA2: sel_byte = d[15:8];
            `FPS_ADDR_PCDATA3: sel_byte = d[23:16];
            `FPS_ADDR_PCDATA4: sel_byte = d[31:24];
            default:           sel_byte = 8'h00;
         endcase
      end
   endfunction

   // Counter bit 1 is hidden so five bits still span past 400 ms
   assign stat_live = {cnt_q[5:2], cnt_q[0],
                       FRAME_SEARCH,
                       CAS_SEARCH,
                       CRC_SEARCH};
   assign tmr_done  = (tmr_q == SEARCH_CYC - 1);
   assign srch_tick = CRC_SEARCH & crc_en_q & tmr_done;
   assign sync_d    = BERT_BIT_VALID ? (BERT_MATCH_BIT & (run_q >= `FPS_BERT_IN_SYNC_RUN - 1))
                                     : sync_q;
   assign bert_in_sync_edge = sync_d ^ sync_q;

   // Register writes
   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         pcptr_q  <= `FPS_RST_BYTE;
         pcdata_q <= 32'h0000_0000;
         hrx1_q   <= `FPS_RST_BYTE;
         hrx2_q   <= `FPS_RST_BYTE;
         crc_en_q <= 1'b0;
         imask_q  <= 2'h0;
      end
      else if (wr_en)
      begin
         case (ADDR)
            `FPS_ADDR_PCPTR:   pcptr_q <= WDATA;
            `FPS_ADDR_PCDATA1: pcdata_q[7:0]   <= WDATA;
            `FPS_ADDR_PCDATA2: pcdata_q[15:8]  <= WDATA;
            `FPS_ADDR_PCDATA3: pcdata_q[23:16] <= WDATA;
            `FPS_ADDR_PCDATA4: pcdata_q[31:24] <= WDATA;
            `FPS_ADDR_HRX1CTL: hrx1_q <= WDATA;
            `FPS_ADDR_HRX2CTL: hrx2_q <= WDATA;
            `FPS_ADDR_IRQMASK: imask_q <= WDATA[1:0];
            `FPS_ADDR_RXCTL:   crc_en_q <= WDATA[`FPS_RXCTL_CRC4_BIT];
            default:           crc_en_q <= crc_en_q;
         endcase
      end
   end

   // Read data, one cycle after the strobe, zero otherwise
   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
         RDATA <= 8'h00;
      else if (CE)
      begin
         if (!rd_en)
            RDATA <= 8'h00;
         else
         begin
            case (ADDR)
               `FPS_ADDR_PCPTR:   RDATA <= pcptr_q;
               `FPS_ADDR_SYNCSTAT: RDATA <= stat_live;
               `FPS_ADDR_HRX1CTL: RDATA <= hrx1_q;
               `FPS_ADDR_HRX2CTL: RDATA <= hrx2_q;
               `FPS_ADDR_IRQSTAT: RDATA <= {6'h00, ist_q};
               `FPS_ADDR_IRQMASK: RDATA <= {6'h00, imask_q};
               `FPS_ADDR_RXCTL:   RDATA <= {7'h00, crc_en_q};
               default:           RDATA <= sel_byte(ADDR, pcdata_q);
            endcase
         end
      end
   end

   // CRC4 multiframe search timer and counter
   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         tmr_q <= 23'h000000;
         cnt_q <= `FPS_RST_CNT;
         crc_srch_q <= 1'b0;
      end
      else if (CE)
      begin
         crc_srch_q <= CRC_SEARCH;
         if (!crc_en_q)
         begin
            cnt_q <= `FPS_RST_CNT;
            tmr_q <= 23'h000000;
         end
         else if (!CRC_SEARCH)
         begin
            // Sync reached: stop timing and forget the search
            tmr_q <= 23'h000000;
            if (crc_srch_q)
               cnt_q <= `FPS_RST_CNT;
         end
         else if (tmr_done)
         begin
            tmr_q <= 23'h000000;
            cnt_q <= cnt_q + 6'h01;
         end
         else
            tmr_q <= tmr_q + 23'h000001;
      end
   end

   // BERT in-sync detector
   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         run_q  <= 6'h00;
         sync_q <= 1'b0;
      end
      else if (CE && BERT_BIT_VALID)
      begin
         if (!BERT_MATCH_BIT)
            run_q <= 6'h00;
         else if (run_q < `FPS_BERT_IN_SYNC_RUN)
            run_q <= run_q + 6'h01;
         sync_q <= sync_d;
      end
   end

   // Sticky status; set wins over clear-on-read
   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         ist_q <= 2'h0;
         IRQ   <= 1'b0;
      end
      else if (CE)
      begin
         ist_q[`FPS_IRQ_BERT_IN_SYNC_BIT] <= bert_in_sync_edge |
            (ist_q[`FPS_IRQ_BERT_IN_SYNC_BIT] & ~(rd_en && ADDR == `FPS_ADDR_IRQSTAT));
         ist_q[`FPS_IRQ_SRCH_BIT] <= srch_tick |
            (ist_q[`FPS_IRQ_SRCH_BIT] & ~(rd_en && ADDR == `FPS_ADDR_IRQSTAT));
         IRQ <= |(ist_q & imask_q);
      end
   end

   // Per-channel enables and HDLC controls
   genvar g;
   generate
      for (g = 0; g < NCHAN; g = g + 1)
      begin : g_chan
         always @(posedge CLK_SYS)
         begin
            if (!RST_N)
            begin
               RX_SIG_ONES_INSERT_EN[g]   <= 1'b0;
               RX_SIG_REINSERT_EN[g]      <= 1'b0;
               RX_FRACTIONAL_EN[g]        <= 1'b0;
               BERT_RX_CHANNEL_EN[g]      <= 1'b0;
               TX_HW_SIGNALING_EN[g]      <= 1'b0;
               PAYLOAD_ERROR_INSERT_EN[g] <= 1'b0;
               TX_FRACTIONAL_EN[g]        <= 1'b0;
               BERT_TX_CHANNEL_EN[g]      <= 1'b0;
            end
            else if (CE)
            begin
               RX_SIG_ONES_INSERT_EN[g]   <= pcptr_q[7] & pcdata_q[g];
               RX_SIG_REINSERT_EN[g]      <= pcptr_q[6] & pcdata_q[g];
               RX_FRACTIONAL_EN[g]        <= pcptr_q[5] & pcdata_q[g];
               BERT_RX_CHANNEL_EN[g]      <= pcptr_q[4] & pcdata_q[g];
               TX_HW_SIGNALING_EN[g]      <= pcptr_q[3] & pcdata_q[g];
               PAYLOAD_ERROR_INSERT_EN[g] <= pcptr_q[2] & pcdata_q[g];
               TX_FRACTIONAL_EN[g]        <= pcptr_q[1] & pcdata_q[g];
               BERT_TX_CHANNEL_EN[g]      <= pcptr_q[0] & pcdata_q[g];
            end
         end
      end
   endgenerate

   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         rst1_q <= 1'b0;
         rst2_q <= 1'b0;
         RX_HDLC_RESET <= 2'h0;
         RX_HDLC_MAP_SELECT <= 2'h0;
         RX_FILL_UNIT_DELETE <= 2'h0;
         BERT_IN_SYNC <= 1'b0;
      end
      else if (CE)
      begin
         rst1_q <= hrx1_q[`FPS_HRX_RESET_BIT];
         rst2_q <= hrx2_q[`FPS_HRX_RESET_BIT];
         // One pulse per 0-to-1 step; holding the bit does not repeat it
         RX_HDLC_RESET <= {hrx2_q[`FPS_HRX_RESET_BIT] & ~rst2_q,
                           hrx1_q[`FPS_HRX_RESET_BIT] & ~rst1_q};
         RX_HDLC_MAP_SELECT <= {hrx2_q[`FPS_HRX_MAP_BIT], hrx1_q[`FPS_HRX_MAP_BIT]};
         RX_FILL_UNIT_DELETE <= {hrx2_q[`FPS_HRX_FISU_BIT], hrx1_q[`FPS_HRX_FISU_BIT]};
         BERT_IN_SYNC <= sync_q;
      end
   end

endmodule // fps_perchan_sync_status

// ==== src/fps_regs.vh ====
`ifndef FPS_REGS_VH
`define FPS_REGS_VH
// Register offsets (byte addresses on the plain port)
`define FPS_ADDR_PCPTR     8'h28
`define FPS_ADDR_PCDATA1   8'h29
`define FPS_ADDR_PCDATA2   8'h2A
`define FPS_ADDR_PCDATA3   8'h2B
`define FPS_ADDR_PCDATA4   8'h2C
`define FPS_ADDR_SYNCSTAT  8'h30
`define FPS_ADDR_HRX1CTL   8'h31
`define FPS_ADDR_HRX2CTL   8'h32
`define FPS_ADDR_IRQSTAT   8'h40
`define FPS_ADDR_IRQMASK   8'h41
`define FPS_ADDR_RXCTL     8'h42
// Field positions
`define FPS_HRX_RESET_BIT  7
`define FPS_HRX_MAP_BIT    6
`define FPS_HRX_FISU_BIT   0
`define FPS_RXCTL_CRC4_BIT 0
`define FPS_IRQ_BERT_IN_SYNC_BIT  0
`define FPS_IRQ_SRCH_BIT   1
// Reset values
`define FPS_RST_BYTE       8'h00
`define FPS_RST_CNT        6'h00
// Timing
`define FPS_CLK_HZ         40000000
`define FPS_SEARCH_MS      8
`define FPS_SEARCH_CYC     ((`FPS_CLK_HZ / 1000) * `FPS_SEARCH_MS)
`define FPS_BERT_IN_SYNC_RUN      32
`endif

// ==== testbench/fps_checker.sv ====
`timescale 1ns/1ps
module fps_checker
#(
   parameter NCHAN = 32
)
(
   input wire logic             CLK_SYS,
   input wire logic             RST_N,
   input wire logic             WR,
   input wire logic             RD,
   input wire logic [7:0]       ADDR,
   input wire logic [7:0]       WDATA,
   input wire logic [7:0]       RDATA,
   input wire logic             CRC_SEARCH,
   input wire logic             BERT_MATCH_BIT,
   input wire logic             BERT_BIT_VALID,
   input wire logic             BERT_IN_SYNC,
   input wire logic             IRQ,
   input wire logic [NCHAN-1:0] RX_SIG_ONES_INSERT_EN,
   input wire logic [NCHAN-1:0] BERT_TX_CHANNEL_EN,
   input wire logic [1:0]       RX_HDLC_RESET,
   input wire logic [1:0]       RX_HDLC_MAP_SELECT
);
   logic [5:0] run_q;
   logic [7:0] mask_q;
   // Saturates so a long run never wraps back under the sync count
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N || (BERT_BIT_VALID && !BERT_MATCH_BIT))
         run_q <= 6'h00;
      else if (BERT_BIT_VALID && run_q != 6'h3F)
         run_q <= run_q + 6'h01;
      if (!RST_N)
         mask_q <= 8'h00;
      else if (WR && ADDR == 8'h41)
         mask_q <= WDATA;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   sequence s_stat_rd; RD && ADDR == 8'h30; endsequence
   sequence s_ptr_wr; WR && ADDR == 8'h28; endsequence
   rd_idle_a: assert property (!RD |=> RDATA == 8'h00) else $error("rdata not idle");
   live_crc_a: assert property (s_stat_rd |=> RDATA[0] == $past(CRC_SEARCH))
      else $error("status bit0 wrong");
   count_clear_a: assert property (s_stat_rd ##0 (!CRC_SEARCH && !$past(CRC_SEARCH)
      && !$past(CRC_SEARCH, 2)) |=> RDATA[7:3] == 5'h00) else $error("count not cleared");
   ptr_hi_a: assert property (s_ptr_wr ##0 !WDATA[7] |-> ##2 RX_SIG_ONES_INSERT_EN == 0)
      else $error("bit7 function on");
   ptr_lo_a: assert property (s_ptr_wr ##0 !WDATA[0] |-> ##2 BERT_TX_CHANNEL_EN == 0)
      else $error("bit0 function on");
   rst_pulse_a: assert property (RX_HDLC_RESET[0] |=> !RX_HDLC_RESET[0])
      else $error("hdlc reset too long");
   rst_cause_a: assert property (RX_HDLC_RESET[0] |-> $past(WR, 2) &&
      $past(ADDR, 2) == 8'h31 && $past(WDATA[7], 2)) else $error("hdlc reset uncaused");
   map_sel_a: assert property (WR && ADDR == 8'h32 |-> ##2
      RX_HDLC_MAP_SELECT[1] == $past(WDATA[6], 2)) else $error("map select wrong");
   sync_run_a: assert property ($rose(BERT_IN_SYNC) |-> $past(run_q) >= 6'h20)
      else $error("sync too early");
   sync_drop_a: assert property (BERT_BIT_VALID && !BERT_MATCH_BIT |-> ##2 !BERT_IN_SYNC)
      else $error("sync kept");
   irq_mask_a: assert property (mask_q == 0 && $past(mask_q) == 0 &&
      $past(mask_q, 2) == 0 |-> !IRQ) else $error("masked irq");
   irq_edge_a: assert property ($changed(BERT_IN_SYNC) && mask_q[0] |-> ##[0:3] IRQ)
      else $error("edge irq missing");
endmodule // fps_checker

// ==== testbench/fps_host.sv ====
`timescale 1ns/1ps
module fps_host
(
   // Register port, master side
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd
);
   initial {addr, wdata, wr, rd} = 18'h00000;
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
endmodule // fps_host

// ==== testbench/framer_perchan_sync_status_bench.sv ====
`timescale 1ns/1ps
module framer_perchan_sync_status_bench;
   logic CLK_SYS, RST_N, FRAME_SEARCH, CAS_SEARCH, CRC_SEARCH, BERT_MATCH_BIT, BERT_BIT_VALID;
   wire [7:0] ADDR, WDATA, RDATA;
   wire WR, RD, BERT_IN_SYNC, IRQ;
   wire [31:0] en [0:7];
   wire [1:0] hrst, hmap, hfill;
   integer fails = 0, n_tests = 0, seed = 99, cyc = 0, np0 = 0, np1 = 0, t0, i, k;
   int pts [4] = '{3, 45, 66, 67};
   logic [7:0] rv, p;
   logic [31:0] dv;
   fps_host u_fps_host (.clk(CLK_SYS), .rdata(RDATA), .addr(ADDR), .wdata(WDATA), .wr(WR),
      .rd(RD));
   fps_perchan_sync_status #(.SEARCH_CYC(10)) u_fps_perchan_sync_status (.CLK_SYS(CLK_SYS),
      .RST_N(RST_N), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .FRAME_SEARCH(FRAME_SEARCH), .CAS_SEARCH(CAS_SEARCH), .CRC_SEARCH(CRC_SEARCH),
      .BERT_MATCH_BIT(BERT_MATCH_BIT), .BERT_BIT_VALID(BERT_BIT_VALID),
      .RX_SIG_ONES_INSERT_EN(en[7]), .RX_SIG_REINSERT_EN(en[6]), .RX_FRACTIONAL_EN(en[5]),
      .BERT_RX_CHANNEL_EN(en[4]), .TX_HW_SIGNALING_EN(en[3]), .PAYLOAD_ERROR_INSERT_EN(en[2]),
      .TX_FRACTIONAL_EN(en[1]), .BERT_TX_CHANNEL_EN(en[0]), .RX_HDLC_RESET(hrst),
      .RX_HDLC_MAP_SELECT(hmap), .RX_FILL_UNIT_DELETE(hfill), .BERT_IN_SYNC(BERT_IN_SYNC),
      .IRQ(IRQ));
   task automatic print_verdict;
      if (fails == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_fps_host.rd_reg(a, rv);
      chk("rdata", {24'h0, e}, {24'h0, rv});
   endtask
   // Expected status byte; bit 1 of the count is never shown
   function automatic logic [7:0] stat(input int n);
      logic [5:0] c;
      c = n[5:0];
      stat = {c[5:2], c[0], FRAME_SEARCH, CAS_SEARCH, CRC_SEARCH};
   endfunction
   task automatic feed(input int n, input logic m);
      repeat (n)
      begin
         @(posedge CLK_SYS);
         BERT_BIT_VALID <= 1'b1;
         BERT_MATCH_BIT <= m;
      end
      @(posedge CLK_SYS);
      BERT_BIT_VALID <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      #1;
   endtask
   initial
   begin
      CLK_SYS = 1'b0;
      forever #12.5 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS)
   begin
      cyc <= cyc + 1;
      np0 <= RST_N ? np0 + hrst[0] : 0;
      np1 <= RST_N ? np1 + hrst[1] : 0;
   end
   initial
   begin
      #500000;
      fails++;
      print_verdict;
   end
   initial
   begin
      RST_N = 1'b0;
      {FRAME_SEARCH, CAS_SEARCH, CRC_SEARCH, BERT_MATCH_BIT, BERT_BIT_VALID} = 5'h00;
      repeat (4) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      for (i = 8'h28; i < 8'h45; i++)
         rchk(i[7:0], 8'h00);
      repeat (4)
      begin
         p = $random(seed);
         dv = $random(seed);
         u_fps_host.wr_reg(8'h28, p);
         for (k = 0; k < 4; k++)
            u_fps_host.wr_reg(8'h29 + k[7:0], dv[8*k +: 8]);
         repeat (2) @(posedge CLK_SYS);
         #1;
         for (k = 0; k < 8; k++)
            chk("enable", p[k] ? dv : 32'h0, en[k]);
         rchk(8'h28, p);
         rchk(8'h2C, dv[31:24]);
         {FRAME_SEARCH, CAS_SEARCH} <= 2'($random(seed));
         u_fps_host.wr_reg(8'h30, 8'hFF);
         rchk(8'h30, stat(0));
      end
      u_fps_host.wr_reg(8'h42, 8'h01);
      CRC_SEARCH <= 1'b1;
      t0 = cyc;
      for (k = 0; k < 4; k++)
      begin
         while (cyc < t0 + 5 + 10 * pts[k])
            @(posedge CLK_SYS);
         rchk(8'h30, stat(pts[k]));
      end
      CRC_SEARCH <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      rchk(8'h30, stat(0));
      CRC_SEARCH <= 1'b1;
      repeat (35) @(posedge CLK_SYS);
      u_fps_host.wr_reg(8'h42, 8'h00);
      repeat (2) @(posedge CLK_SYS);
      rchk(8'h30, stat(0));
      CRC_SEARCH <= 1'b0;
      rchk(8'h40, 8'h02);
      rchk(8'h40, 8'h00);
      u_fps_host.wr_reg(8'h31, 8'h80);
      u_fps_host.wr_reg(8'h31, 8'h80);
      u_fps_host.wr_reg(8'h31, 8'h00);
      u_fps_host.wr_reg(8'h31, 8'h80);
      u_fps_host.wr_reg(8'h32, 8'hC1);
      feed(0, 1'b0);
      chk("pulse", 32'h2, np0);
      chk("pulse", 32'h1, np1);
      chk("ctl", 32'hA, {hmap, hfill});
      u_fps_host.wr_reg(8'h41, 8'h01);
      feed(31, 1'b1);
      chk("sync", 32'h0, BERT_IN_SYNC);
      feed(1, 1'b1);
      chk("sync", 32'h1, BERT_IN_SYNC);
      chk("irq", 32'h1, IRQ);
      rchk(8'h40, 8'h01);
      feed(1, 1'b0);
      chk("irq", 32'h1, IRQ);
      rchk(8'h40, 8'h01);
      u_fps_host.wr_reg(8'h41, 8'h00);
      feed(32, 1'b1);
      chk("irq", 32'h0, IRQ);
      rchk(8'h40, 8'h01);
      print_verdict;
   end
endmodule // framer_perchan_sync_status_bench
bind fps_perchan_sync_status fps_checker #(.NCHAN(NCHAN)) u_fps_checker (.*);
